// File: jid_defs.svh
`ifndef JID_DEFS_SVH
`define JID_DEFS_SVH

// Instruction width and the fixed pattern loaded on instruction capture
`define JID_INS_W 7
`define JID_INS_CAPT 7'h01

// Opcodes
`define JID_OP_EXTEST 7'h00
`define JID_OP_SAMPLE 7'h01
`define JID_OP_DBG_RX 7'h02
`define JID_OP_CLAMP 7'h04
`define JID_OP_ICACHE 7'h07
`define JID_OP_HIGHZ 7'h08
`define JID_OP_DBG_STAT 7'h09
`define JID_OP_DBG_TX 7'h10
`define JID_OP_FL_STAGE 7'h36
`define JID_OP_FL_DRIVE 7'h37
`define JID_OP_IDCODE 7'h7e
`define JID_OP_BYPASS 7'h7f

// Identification register width
`define JID_ID_W 32

// Debug data register slots
`define JID_DBG_IDX_W 2
`define JID_DBG_RX 2'h0
`define JID_DBG_STAT 2'h1
`define JID_DBG_TX 2'h2
`define JID_DBG_ICACHE 2'h3

`endif

// File: jid_pkg.sv
`default_nettype none
package jid_pkg;

   // Test access port controller states, one-hot
   typedef enum logic [15:0] {
      TAP_RESET = 16'h0001,
      TAP_IDLE = 16'h0002,
      TAP_SEL_DAT = 16'h0004,
      TAP_CAP_DAT = 16'h0008,
      TAP_SHIFT_DAT = 16'h0010,
      TAP_EXIT1_DAT = 16'h0020,
      TAP_PAUSE_DAT = 16'h0040,
      TAP_EXIT2_DAT = 16'h0080,
      TAP_UPD_DAT = 16'h0100,
      TAP_SEL_INS = 16'h0200,
      TAP_CAP_INS = 16'h0400,
      TAP_SHIFT_INS = 16'h0800,
      TAP_EXIT1_INS = 16'h1000,
      TAP_PAUSE_INS = 16'h2000,
      TAP_EXIT2_INS = 16'h4000,
      TAP_UPD_INS = 16'h8000
   } jid_tap_t;

   // Serial path between data in and data out
   typedef enum logic [4:0] {
      PATH_BYP = 5'h01,
      PATH_BSR = 5'h02,
      PATH_FLASH = 5'h04,
      PATH_ID = 5'h08,
      PATH_DBG = 5'h10
   } jid_path_t;

endpackage
`default_nettype wire

// File: jid_instruction_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "jid_defs.svh"
// Summary of operation
// R01 - Seven-bit instruction selects operation and path
// R02 - Data in enters MSB, LSB faces out
// R03 - One bit shifts per rising test clock
// R04 - Test reset makes idcode current
// R05 - Runbist, intest and usercode not implemented
// R06 - Extest puts boundary register in path
// R07 - Extest drives pins, updates on falling edge
// R08 - Extest captures input pins at capture
// R09 - Scanned input cells never reach core
// R10 - Sample captures pins without disturbing operation
// R11 - Preload copies cells to update stage
// R12 - Clamp holds pins, bypass in path
// R13 - Highz floats all pins, bypass in path
// R14 - Flash stage acts as preload on subset
// R15 - Flash drive drives subset pins only
// R16 - Idcode loads fixed 32-bit code
// R17 - Shifting never alters stored identification code
// R18 - Bypass in path, captures zero
// R19 - Under bypass pins follow system logic
// R20 - Icache load opcode selects its register
// R21 - Data out changes falling, floats otherwise
// R22 - Bypass delays data exactly one clock
// R23 - Boundary path only for sample, extest; flash opcodes also capture, shift and update part of it
// R24 - Debug opcodes select distinct debug registers
// R25 - Private opcodes decode safely to bypass
module jid_instruction_decode
   import jid_pkg::*;
#(
   parameter int PIN_N = 8,
   parameter int FLASH_N = 4,
   parameter int DBG_W = 32,
   parameter logic [`JID_ID_W-1:0] ID_CODE = 32'h0abc_de01 // Arbitrary value
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   input wire logic trst_n_i,
   input wire logic [PIN_N-1:0] pin_in_i,
   input wire logic [PIN_N-1:0] core_out_i,
   input wire logic [PIN_N-1:0] core_oe_i,
   input wire logic [DBG_W-1:0] dbg_cap_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   output logic [PIN_N-1:0] pin_out_o,
   output logic [PIN_N-1:0] pin_oe_o,
   output logic [PIN_N-1:0] core_in_o,
   output logic [`JID_INS_W-1:0] instr_o,
   output logic [DBG_W-1:0] dbg_data_o,
   output logic [`JID_DBG_IDX_W-1:0] dbg_sel_o,
   output logic dbg_upd_o
);

   localparam int BSR_W = 2 * PIN_N;
   localparam int DBG_N = 4;

   logic tck_s1_reg, tms_s1_reg, tdi_s1_reg, trst_s1_reg;
   logic tck_s2_reg, tms_s2_reg, tdi_s2_reg, trst_s2_reg;
   logic tck_d_reg;
   logic [PIN_N-1:0] pin_s1_reg, pin_s2_reg;
   logic tck_rise, tck_fall;
   jid_tap_t tap_reg;
   logic [`JID_INS_W-1:0] ins_sh_reg;
   logic [`JID_INS_W-1:0] instr_reg;
   jid_path_t path;
   logic [`JID_DBG_IDX_W-1:0] dbg_idx;
   logic byp_reg;
   logic [`JID_ID_W-1:0] id_sh_reg;
   logic [BSR_W-1:0] bsr_reg;
   logic [BSR_W-1:0] upd_reg;
   logic [DBG_W-1:0] dbg_sh_reg [DBG_N];
   logic ser_out;

   // Controller walk on each test clock rising edge
   function automatic jid_tap_t jid_next(input jid_tap_t s, input logic tms);
      unique case (s)
         TAP_RESET: jid_next = tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: jid_next = tms ? TAP_SEL_DAT : TAP_IDLE;
         TAP_SEL_DAT: jid_next = tms ? TAP_SEL_INS : TAP_CAP_DAT;
         TAP_CAP_DAT: jid_next = tms ? TAP_EXIT1_DAT : TAP_SHIFT_DAT;
         TAP_SHIFT_DAT: jid_next = tms ? TAP_EXIT1_DAT : TAP_SHIFT_DAT;
         TAP_EXIT1_DAT: jid_next = tms ? TAP_UPD_DAT : TAP_PAUSE_DAT;
         TAP_PAUSE_DAT: jid_next = tms ? TAP_EXIT2_DAT : TAP_PAUSE_DAT;
         TAP_EXIT2_DAT: jid_next = tms ? TAP_UPD_DAT : TAP_SHIFT_DAT;
         TAP_UPD_DAT: jid_next = tms ? TAP_SEL_DAT : TAP_IDLE;
         TAP_SEL_INS: jid_next = tms ? TAP_RESET : TAP_CAP_INS;
         TAP_CAP_INS: jid_next = tms ? TAP_EXIT1_INS : TAP_SHIFT_INS;
         TAP_SHIFT_INS: jid_next = tms ? TAP_EXIT1_INS : TAP_SHIFT_INS;
         TAP_EXIT1_INS: jid_next = tms ? TAP_UPD_INS : TAP_PAUSE_INS;
         TAP_PAUSE_INS: jid_next = tms ? TAP_EXIT2_INS : TAP_PAUSE_INS;
         TAP_EXIT2_INS: jid_next = tms ? TAP_UPD_INS : TAP_SHIFT_INS;
         TAP_UPD_INS: jid_next = tms ? TAP_SEL_DAT : TAP_IDLE;
         default: jid_next = TAP_RESET;
      endcase
   endfunction

   // Pin synchronisers; the test clock is sampled, not used as a clock
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         {trst_s1_reg, tdi_s1_reg, tms_s1_reg, tck_s1_reg} <= 4'h0;
         {trst_s2_reg, tdi_s2_reg, tms_s2_reg, tck_s2_reg} <= 4'h0;
         tck_d_reg <= 1'b0;
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end else if (ce_i) begin
         {trst_s1_reg, tdi_s1_reg, tms_s1_reg, tck_s1_reg} <= {trst_n_i, tdi_i, tms_i, tck_i};
         {trst_s2_reg, tdi_s2_reg, tms_s2_reg, tck_s2_reg} <=
            {trst_s1_reg, tdi_s1_reg, tms_s1_reg, tck_s1_reg};
         tck_d_reg <= tck_s2_reg;
         pin_s1_reg <= pin_in_i;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   assign tck_rise = ce_i & trst_s2_reg & tck_s2_reg & ~tck_d_reg;
   assign tck_fall = ce_i & trst_s2_reg & ~tck_s2_reg & tck_d_reg;

   // Controller state; test reset forces the reset state without a clock edge
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         tap_reg <= TAP_RESET;
      end else if (ce_i && !trst_s2_reg) begin
         tap_reg <= TAP_RESET;
      end else if (tck_rise) begin
         tap_reg <= jid_next(tap_reg, tms_s2_reg); // R03
      end
   end

   // Instruction shift stage: capture pattern, then data in enters at the top
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ins_sh_reg <= `JID_INS_CAPT;
      end else if (tck_rise) begin
         if (tap_reg == TAP_CAP_INS) begin
            ins_sh_reg <= `JID_INS_CAPT;
         end else if (tap_reg == TAP_SHIFT_INS) begin
            ins_sh_reg <= {tdi_s2_reg, ins_sh_reg[`JID_INS_W-1:1]}; // R02 R03
         end
      end
   end

   // Current instruction takes a shifted opcode only on a falling edge, so pins never see a half shift
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         instr_reg <= `JID_OP_IDCODE;
      end else if (ce_i && (!trst_s2_reg || tap_reg == TAP_RESET)) begin
         instr_reg <= `JID_OP_IDCODE; // R04
      end else if (tck_fall && tap_reg == TAP_UPD_INS) begin
         instr_reg <= ins_sh_reg; // R01 R15
      end
   end

   // Path decode; unlisted and unimplemented opcodes fall to bypass
   always_comb begin
      path = PATH_BYP;
      dbg_idx = `JID_DBG_RX;
      unique case (instr_reg)
         `JID_OP_EXTEST, `JID_OP_SAMPLE: path = PATH_BSR; // R06 R23
         `JID_OP_FL_STAGE, `JID_OP_FL_DRIVE: path = PATH_FLASH; // R14
         `JID_OP_IDCODE: path = PATH_ID; // R16
         `JID_OP_DBG_RX: path = PATH_DBG; // R24
         `JID_OP_DBG_STAT: begin
            path = PATH_DBG; // R24
            dbg_idx = `JID_DBG_STAT;
         end
         `JID_OP_DBG_TX: begin
            path = PATH_DBG; // R24
            dbg_idx = `JID_DBG_TX;
         end
         `JID_OP_ICACHE: begin
            path = PATH_DBG; // R20
            dbg_idx = `JID_DBG_ICACHE;
         end
         default: path = PATH_BYP; // R05 R12 R13 R18 R25
      endcase
   end

   // Serial data registers: capture then shift on rising edges
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         byp_reg <= 1'b0;
         id_sh_reg <= ID_CODE;
         bsr_reg <= '0;
         for (int i = 0; i < DBG_N; i++) begin
            dbg_sh_reg[i] <= '0;
         end
      end else if (tck_rise && tap_reg == TAP_CAP_DAT) begin
         unique case (path)
            PATH_BYP: byp_reg <= 1'b0; // R18
            PATH_BSR: bsr_reg <= {core_out_i, pin_s2_reg}; // R08 R10
            PATH_FLASH: bsr_reg[PIN_N +: FLASH_N] <= core_out_i[FLASH_N-1:0]; // R14
            PATH_ID: id_sh_reg <= ID_CODE; // R16 R17
            PATH_DBG: dbg_sh_reg[dbg_idx] <= dbg_cap_i;
         endcase
      end else if (tck_rise && tap_reg == TAP_SHIFT_DAT) begin
         unique case (path)
            PATH_BYP: byp_reg <= tdi_s2_reg; // R22
            PATH_BSR: bsr_reg <= {tdi_s2_reg, bsr_reg[BSR_W-1:1]}; // R06
            PATH_FLASH: bsr_reg[PIN_N +: FLASH_N] <=
               {tdi_s2_reg, bsr_reg[PIN_N+FLASH_N-1:PIN_N+1]}; // R14
            PATH_ID: id_sh_reg <= {tdi_s2_reg, id_sh_reg[`JID_ID_W-1:1]};
            PATH_DBG: dbg_sh_reg[dbg_idx] <= {tdi_s2_reg, dbg_sh_reg[dbg_idx][DBG_W-1:1]};
         endcase
      end
   end

   // Update stage and debug hand-off on the falling edge in update
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         upd_reg <= '0;
         dbg_data_o <= '0;
         dbg_sel_o <= `JID_DBG_RX;
         dbg_upd_o <= 1'b0;
      end else if (ce_i) begin
         dbg_upd_o <= 1'b0;
         if (tck_fall && tap_reg == TAP_UPD_DAT) begin
            unique case (path)
               PATH_BSR: upd_reg <= bsr_reg; // R07 R11
               PATH_FLASH: upd_reg[PIN_N +: FLASH_N] <= bsr_reg[PIN_N +: FLASH_N]; // R14
               PATH_DBG: begin
                  dbg_data_o <= dbg_sh_reg[dbg_idx]; // R24
                  dbg_sel_o <= dbg_idx;
                  dbg_upd_o <= 1'b1;
               end
               default: upd_reg <= upd_reg; // R23
            endcase
         end
      end
   end

   // Pin muxing; inputs always reach the core straight from the pins
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pin_out_o <= '0;
         pin_oe_o <= '0;
         core_in_o <= '0;
         instr_o <= `JID_OP_IDCODE;
      end else if (ce_i) begin
         core_in_o <= pin_s2_reg; // R09
         instr_o <= instr_reg;
         pin_out_o <= core_out_i; // R10 R19
         pin_oe_o <= core_oe_i;
         if (instr_reg == `JID_OP_EXTEST || instr_reg == `JID_OP_CLAMP) begin
            pin_out_o <= upd_reg[BSR_W-1:PIN_N]; // R07 R12
            pin_oe_o <= '1;
         end else if (instr_reg == `JID_OP_HIGHZ) begin
            pin_oe_o <= '0; // R13
         end else if (instr_reg == `JID_OP_FL_DRIVE) begin
            pin_out_o[FLASH_N-1:0] <= upd_reg[PIN_N +: FLASH_N]; // R15
            pin_oe_o[FLASH_N-1:0] <= '1;
         end
      end
   end

   // Serial output select
   always_comb begin
      ser_out = byp_reg;
      if (tap_reg == TAP_SHIFT_INS) begin
         ser_out = ins_sh_reg[0]; // R02
      end else begin
         unique case (path)
            PATH_BYP: ser_out = byp_reg; // R22
            PATH_BSR: ser_out = bsr_reg[0];
            PATH_FLASH: ser_out = bsr_reg[PIN_N];
            PATH_ID: ser_out = id_sh_reg[0];
            PATH_DBG: ser_out = dbg_sh_reg[dbg_idx][0];
         endcase
      end
   end

   // Data out moves on the falling edge so the master samples it stable
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         tdo_o <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (ce_i && !trst_s2_reg) begin
         tdo_oe_o <= 1'b0;
      end else if (tck_fall) begin
         tdo_o <= ser_out; // R21
         tdo_oe_o <= (tap_reg == TAP_SHIFT_INS) || (tap_reg == TAP_SHIFT_DAT); // R21
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);

   chk_test_reset_id: assert property ((ce_i && !trst_s2_reg) |=> // R04
      instr_reg == `JID_OP_IDCODE) else $error("test reset did not select idcode");
   chk_ins_load: assert property ((tck_fall && tap_reg == TAP_UPD_INS) |=> // R01
      instr_reg == $past(ins_sh_reg)) else $error("instruction not loaded at update");
   chk_ins_shift_in: assert property ((tck_rise && tap_reg == TAP_SHIFT_INS) |=> // R02
      ins_sh_reg[`JID_INS_W-1] == $past(tdi_s2_reg) &&
      ins_sh_reg[`JID_INS_W-2:0] == $past(ins_sh_reg[`JID_INS_W-1:1]))
      else $error("instruction shift wrong");
   chk_tdo_float: assert property ((tck_fall && tap_reg != TAP_SHIFT_INS && // R21
      tap_reg != TAP_SHIFT_DAT) |=> !tdo_oe_o) else $error("data out driven outside shift");
   chk_bypass_zero: assert property ((tck_rise && tap_reg == TAP_CAP_DAT && // R18
      path == PATH_BYP) |=> !byp_reg) else $error("bypass did not capture zero");
   chk_id_load: assert property ((tck_rise && tap_reg == TAP_CAP_DAT && // R16
      path == PATH_ID) |=> id_sh_reg == ID_CODE) else $error("id code not loaded");
   chk_highz_float: assert property ((ce_i && instr_reg == `JID_OP_HIGHZ) |=> // R13
      pin_oe_o == '0) else $error("pins driven under highz");
   chk_clamp_hold: assert property ((instr_reg == `JID_OP_CLAMP) |=> // R12
      $stable(upd_reg)) else $error("update stage changed under clamp");
   chk_core_inputs: assert property (ce_i |=> // R09
      core_in_o == $past(pin_s2_reg)) else $error("core inputs not from pins");
   chk_extest_drive: assert property ((ce_i && instr_reg == `JID_OP_EXTEST) |=> // R07
      pin_out_o == $past(upd_reg[BSR_W-1:PIN_N]) && pin_oe_o == '1)
      else $error("extest pins not from update stage");

endmodule
`default_nettype wire

// File: jid_jtag_master.sv
`timescale 1ns/1ps
`default_nettype none
// Test master model; its clock stands still between frames
module jid_jtag_master (
   input wire logic tdo_i,
   input wire logic tdo_oe_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   output logic trst_n_o
);
   logic line_last;

   // Mode and data start high, as pull-ups would hold them; scans end with mode low
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
      trst_n_o = 1'b1;
      line_last = 1'b0;
   end

   // One clock: set mode and data, read data out just before the rise
   task automatic tick(input logic md, input logic dv, output logic q);
      tms_o = md;
      tdi_o = dv;
      #160;
      q = tdo_oe_i ? tdo_i : ~line_last; // Undriven line gives no trustworthy level
      line_last = q;
      tck_o = 1'b1;
      #160;
      tck_o = 1'b0;
   endtask

   // Full scan ending in idle, LSB first; the opening low-mode tick also leaves test reset
   task automatic scan(input bit ir, input int n, input logic [31:0] d,
                       output logic [31:0] q);
      logic b;
      q = '0;
      tick(1'b0, 1'b1, b);
      tick(1'b1, 1'b1, b);
      if (ir) tick(1'b1, 1'b1, b);
      tick(1'b0, 1'b1, b);
      tick(1'b0, 1'b1, b);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, d[i], b);
         q[i] = b;
      end
      tick(1'b1, 1'b1, b);
      tick(1'b0, 1'b1, b); // Leaves data in high, as its pull-up would
   endtask

   // Test reset pulse held well past the synchroniser
   task automatic pulse_trst();
      trst_n_o = 1'b0;
      #320;
      trst_n_o = 1'b1;
      #320;
   endtask
endmodule
`default_nettype wire

// File: jid_instruction_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "jid_defs.svh"
module jid_instruction_decode_test;
   localparam logic [31:0] ID_V = 32'h1357_9bdf; // Arbitrary code
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] pi = 8'h00, co = 8'h00, coe = 8'h00, mu;
   logic [31:0] dcap = 32'h0;
   wire tck, tms, tdi, trst_n;
   logic tdo, tdo_oe, dbg_upd;
   logic [7:0] pin_out, pin_oe, core_in;
   logic [6:0] instr;
   logic [31:0] dbg_data;
   logic [1:0] dbg_sel;
   int mismatches = 0, checks = 0, pulses = 0;
   logic [6:0] byp [5] = '{`JID_OP_CLAMP, `JID_OP_HIGHZ, `JID_OP_BYPASS, 7'h03, 7'h5a};
   logic [6:0] dop [4] = '{`JID_OP_DBG_RX, `JID_OP_DBG_STAT, `JID_OP_DBG_TX, `JID_OP_ICACHE};

   jid_instruction_decode #(.PIN_N(8), .FLASH_N(4), .DBG_W(32), .ID_CODE(ID_V)) dut (
      .core_clk_i(clk), .reset_i(rst), .ce_i(1'b1), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .trst_n_i(trst_n), .pin_in_i(pi), .core_out_i(co),
      .core_oe_i(coe), .dbg_cap_i(dcap), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
      .pin_out_o(pin_out), .pin_oe_o(pin_oe), .core_in_o(core_in),
      .instr_o(instr), .dbg_data_o(dbg_data), .dbg_sel_o(dbg_sel), .dbg_upd_o(dbg_upd));
   jid_jtag_master m (.tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
      .tdi_o(tdi), .trst_n_o(trst_n));

   // Core clock, 40 ns period
   always #20 clk = ~clk;

   // Count update pulses from the debug handoff
   always @(posedge clk) if (dbg_upd === 1'b1) pulses <= pulses + 1;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Reference serial path: captured bits leave first, shifted-in bits queue behind them
   function automatic logic [31:0] ref_shift(input logic [31:0] cap, input int w, input int n,
                                             input logic [31:0] din);
      logic q_bits [$];
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < w; i++) begin
         q_bits.push_back(cap[i]);
      end
      for (int i = 0; i < n; i++) begin
         r[i] = q_bits.pop_front();
         q_bits.push_back(din[i]);
      end
      return r;
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // New pad and core values at the falling edge, then let the synchronisers settle
   task automatic new_pins();
      logic [31:0] r;
      @(negedge clk);
      r = $urandom;
      co = r[7:0];
      pi = r[15:8];
      coe = r[23:16];
      dcap = $urandom;
      repeat (6) @(negedge clk);
   endtask

   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      test_done();
   end

   initial begin
      logic [31:0] q, d;
      int n;
      void'($urandom(24448));
      repeat (3) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (8) @(negedge clk);
      chk("instr", 7'h7e, instr);
      chk("tdo_oe", 1'b0, tdo_oe);
      for (int k = 0; k < 2; k++) begin
         d = $urandom;
         m.scan(0, 32, d, q);
         chk("idcode", ref_shift(ID_V, 32, 32, d), q);
      end
      $display("test idcode done");
      for (int k = 0; k < 5; k++) begin
         m.scan(1, 7, {25'h0, byp[k]}, q);
         chk("ir_capture", ref_shift(`JID_INS_CAPT, 7, 7, byp[k]), q[6:0]);
         chk("instr", byp[k], instr);
         d = $urandom;
         m.scan(0, 8, d, q);
         chk("bypass", ref_shift(32'h0, 1, 8, d), q[7:0]);
      end
      $display("test bypass done");
      new_pins();
      m.scan(1, 7, `JID_OP_SAMPLE, q);
      d = $urandom;
      m.scan(0, 16, d, q);
      chk("sample", ref_shift({16'h0, co, pi}, 16, 16, d), q[15:0]);
      chk("sample_out", co, pin_out);
      chk("sample_oe", coe, pin_oe);
      mu = d[15:8];
      m.scan(1, 7, `JID_OP_EXTEST, q);
      chk("extest_out", mu, pin_out);
      chk("extest_oe", 8'hff, pin_oe);
      new_pins();
      d = $urandom;
      m.scan(0, 16, d, q);
      chk("extest_cap", ref_shift({16'h0, co, pi}, 16, 16, d), q[15:0]);
      chk("extest_out", d[15:8], pin_out);
      chk("core_in", pi, core_in);
      mu = d[15:8];
      new_pins();
      m.scan(1, 7, `JID_OP_CLAMP, q);
      m.scan(0, 16, $urandom, q);
      chk("clamp_out", mu, pin_out);
      m.scan(1, 7, `JID_OP_HIGHZ, q);
      chk("highz_oe", 8'h00, pin_oe);
      m.scan(1, 7, `JID_OP_BYPASS, q);
      chk("bypass_out", co, pin_out);
      chk("bypass_oe", coe, pin_oe);
      $display("test boundary done");
      m.scan(1, 7, `JID_OP_FL_STAGE, q);
      d = $urandom;
      m.scan(0, 4, d, q);
      chk("flash_cap", ref_shift({28'h0, co[3:0]}, 4, 4, d), q[3:0]);
      chk("flash_stage_out", co, pin_out);
      m.scan(1, 7, `JID_OP_FL_DRIVE, q);
      chk("flash_out", {co[7:4], d[3:0]}, pin_out);
      chk("flash_oe", {coe[7:4], 4'hf}, pin_oe);
      $display("test flash done");
      for (int k = 0; k < 4; k++) begin
         new_pins();
         m.scan(1, 7, {25'h0, dop[k]}, q);
         n = pulses;
         d = $urandom;
         m.scan(0, 32, d, q);
         chk("dbg_cap", ref_shift(dcap, 32, 32, d), q);
         chk("dbg_data", d, dbg_data);
         chk("dbg_sel", k, dbg_sel);
         chk("dbg_pulse", n + 1, pulses);
      end
      $display("test debug done");
      m.scan(1, 7, `JID_OP_BYPASS, q);
      m.pulse_trst();
      chk("trst_instr", 7'h7e, instr);
      chk("trst_oe", 1'b0, tdo_oe);
      d = $urandom;
      m.scan(0, 32, d, q);
      chk("trst_idcode", ref_shift(ID_V, 32, 32, d), q);
      $display("test reset done");
      test_done();
   end
endmodule
`default_nettype wire
